// file: inc/fbc_link_if.sv
`timescale 1ns/1ps
// byte register writes from the host controller into the feature space
interface fbc_link_if;
    logic wr_stb; // one-cycle write strobe
    logic [7:0] wr_reg; // register number
    logic [7:0] wr_data; // register value

    modport dev (input wr_stb, input wr_reg, input wr_data);
    modport host (output wr_stb, output wr_reg, output wr_data);
endinterface

// file: inc/fbc_pkg.sv
// Contract
// (R1) bit 222 picks short or long bypass
// (R2) nineteen 4-bit trims packed from bit 140
// (R3) trim codes decode to drive percentages
// (R4) unlock key opens select and write registers
// (R5) select byte is the feature-bit address
// (R6) set command drives selected bit to one
// (R7) host clears write register after each set
// (R8) host changes only bits that differ
// (R9) untouched bits keep defaults; locked writes ignored
package fbc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // link register numbers and command values
    localparam logic [7:0] FBC_REG_UNLOCK = 8'h08; // unlock register
    localparam logic [7:0] FBC_REG_SELECT = 8'h09; // bit-select register
    localparam logic [7:0] FBC_REG_WRITE = 8'h0a; // bit-write register
    localparam logic [7:0] FBC_UNLOCK_KEY = 8'hbb; // key pattern 1011_1011
    localparam logic [7:0] FBC_SET_CMD = 8'h82; // set selected bit, 1000_0010
    localparam logic [7:0] FBC_CLEAR_CMD = 8'h00; // idle value after a set

    ////////////////////////////////////////////////////////////////////////////
    // feature-bit space layout
    localparam logic [7:0] FBC_BYPASS_BIT = 8'hde; // bit 222
    localparam logic [7:0] FBC_TRIM_BASE = 8'h8c; // bit 140
    localparam logic [7:0] FBC_TRIM_LAST = 8'hd7; // bit 215
    localparam int FBC_NUM_OUT = 19; // drive-trim fields
    localparam int FBC_TRIM_W = 4; // bits per trim field
    localparam int FBC_LO = 140; // lowest stored feature bit
    localparam int FBC_HI = 222; // highest stored feature bit
    localparam logic FBC_BIT_RESET = 1'b0; // default of every feature bit

    ////////////////////////////////////////////////////////////////////////////
    // drive-trim codes and the levels they give, in percent
    localparam logic [3:0] FBC_TRIM_100 = 4'h0;
    localparam logic [3:0] FBC_TRIM_90 = 4'h1;
    localparam logic [3:0] FBC_TRIM_80 = 4'h3;
    localparam logic [3:0] FBC_TRIM_70 = 4'h4;
    localparam logic [3:0] FBC_TRIM_60 = 4'h6;
    localparam logic [3:0] FBC_TRIM_50 = 4'h7;
    localparam logic [3:0] FBC_TRIM_40 = 4'ha;
    localparam logic [3:0] FBC_TRIM_30 = 4'hb;
    localparam logic [3:0] FBC_TRIM_20 = 4'hc;
    localparam logic [3:0] FBC_TRIM_10 = 4'he;
    localparam logic [3:0] FBC_TRIM_0 = 4'hf;
    localparam logic [6:0] FBC_PCT_DEFAULT = 7'h64; // 100 percent

    ////////////////////////////////////////////////////////////////////////////
    // host wishbone map and fields
    localparam logic [7:0] FBC_WB_CMD = 8'h00; // field command
    localparam logic [7:0] FBC_WB_STATUS = 8'h04; // status, w1c sticky bits
    localparam int FBC_CMD_ADDR_LSB = 0; // [7:0] first feature bit
    localparam int FBC_CMD_WID_LSB = 8; // [9:8] field width minus one
    localparam int FBC_CMD_VAL_LSB = 12; // [15:12] wanted field value
    localparam int FBC_ST_BUSY = 0; // sequence running
    localparam int FBC_ST_CLR_ERR = 1; // sticky: a one could not be cleared
    localparam int FBC_ST_IGNORED = 2; // sticky: command while busy
    localparam int FBC_ST_CNT_LSB = 8; // [15:8] bits changed so far

    // host sequencer states
    typedef enum logic [5:0] {
        FBC_H_IDLE = 6'h01,
        FBC_H_UNLOCK = 6'h02,
        FBC_H_SELECT = 6'h04,
        FBC_H_SET = 6'h08,
        FBC_H_CLEAR = 6'h10,
        FBC_H_NEXT = 6'h20
    } fbc_hstate_e;

endpackage

// file: src/fbc_device.sv
`timescale 1ns/1ps
// feature-bit space of the clock buffer: unlock, select and set registers
module fbc_device
    import fbc_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // register writes from the host
    fbc_link_if.dev link,
    // analog-facing settings
    output logic bypass_short_o,
    output logic [FBC_NUM_OUT*FBC_TRIM_W-1:0] drive_trim_o,
    output logic [FBC_NUM_OUT*7-1:0] drive_pct_o,
    output logic [FBC_NUM_OUT-1:0] drive_code_bad_o,
    // status
    output logic unlocked_o,
    output logic [7:0] selected_o,
    output logic locked_write_o
);

    ////////////////////////////////////////////////////////////////////////////
    // decode of a drive-trim code into a percentage
    // codes missing from the table keep full drive and are flagged, so an
    // odd code never starves an output by accident
    function automatic logic [7:0] fbc_decode(input logic [3:0] code);
        logic [7:0] res;
        res = {1'b0, FBC_PCT_DEFAULT};
        case (code)
            FBC_TRIM_100: res = 8'h64;
            FBC_TRIM_90: res = 8'h5a;
            FBC_TRIM_80: res = 8'h50;
            FBC_TRIM_70: res = 8'h46;
            FBC_TRIM_60: res = 8'h3c;
            FBC_TRIM_50: res = 8'h32;
            FBC_TRIM_40: res = 8'h28;
            FBC_TRIM_30: res = 8'h1e;
            FBC_TRIM_20: res = 8'h14;
            FBC_TRIM_10: res = 8'h0a;
            FBC_TRIM_0: res = 8'h00;
            default: res = {1'b1, FBC_PCT_DEFAULT}; // undefined code
        endcase
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register state
    logic unlocked_r; // select and write registers open
    logic unlocked_nxt;
    logic [7:0] select_r; // selected feature-bit address
    logic [7:0] select_nxt;
    logic [FBC_HI:FBC_LO] feat_r; // stored feature bits
    logic [FBC_HI:FBC_LO] feat_nxt;
    logic locked_r; // pulse: write refused while locked
    logic locked_nxt;

    // decoded write conditions
    logic wr_unlock; // write to the unlock register
    logic wr_select; // write to the select register
    logic wr_write; // write to the bit-write register
    logic sel_in_trim; // selection inside the trim fields
    logic sel_is_bypass; // selection is the bypass bit

    assign wr_unlock = link.wr_stb && (link.wr_reg == FBC_REG_UNLOCK);
    assign wr_select = link.wr_stb && (link.wr_reg == FBC_REG_SELECT);
    assign wr_write = link.wr_stb && (link.wr_reg == FBC_REG_WRITE);
    assign sel_in_trim = (select_r >= FBC_TRIM_BASE) && (select_r <= FBC_TRIM_LAST);
    assign sel_is_bypass = (select_r == FBC_BYPASS_BIT);

    ////////////////////////////////////////////////////////////////////////////
    // next values of the access registers
    always_comb begin
        unlocked_nxt = unlocked_r;
        select_nxt = select_r;
        feat_nxt = feat_r;
        locked_nxt = 1'b0;
        // key opens, any other value relocks
        if (wr_unlock) begin
            unlocked_nxt = (link.wr_data == FBC_UNLOCK_KEY); // [R4]
        end
        // select byte is the bit address
        if (wr_select) begin
            if (unlocked_r) begin
                select_nxt = link.wr_data; // [R5]
            end else begin
                locked_nxt = 1'b1; // [R9]
            end
        end
        // only the set pattern changes a bit
        if (wr_write) begin
            if (!unlocked_r) begin
                locked_nxt = 1'b1; // [R9]
            end else if (link.wr_data == FBC_SET_CMD) begin
                // unstored bits are ignored
                if (sel_in_trim || sel_is_bypass) begin
                    feat_nxt[select_r] = 1'b1; // [R6]
                end
            end
        end
    end

    // registers of the access logic
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            unlocked_r <= 1'b0;
            select_r <= 8'h00;
            feat_r <= {(FBC_HI-FBC_LO+1){FBC_BIT_RESET}}; // [R9]
            locked_r <= 1'b0;
        end else begin
            unlocked_r <= unlocked_nxt;
            select_r <= select_nxt;
            feat_r <= feat_nxt;
            locked_r <= locked_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // settings outputs, registered from the feature bits
    logic bypass_r; // short bypass delay chosen
    logic bypass_nxt;
    logic [FBC_NUM_OUT*FBC_TRIM_W-1:0] trim_r; // raw trim fields
    logic [FBC_NUM_OUT*FBC_TRIM_W-1:0] trim_nxt;
    logic [FBC_NUM_OUT*7-1:0] pct_r; // decoded drive levels
    logic [FBC_NUM_OUT*7-1:0] pct_nxt;
    logic [FBC_NUM_OUT-1:0] bad_r; // undefined code per output
    logic [FBC_NUM_OUT-1:0] bad_nxt;

    // bit 222: zero keeps the long delay, one picks the short one
    always_comb begin
        bypass_nxt = feat_r[FBC_HI]; // [R1]
    end

    // one trim field per output, packed four bits apart from the base
    genvar n;
    generate
        for (n = 0; n < FBC_NUM_OUT; n++) begin : g_out
            logic [7:0] dec; // decoded level with bad-code flag on top
            always_comb begin
                trim_nxt[n*FBC_TRIM_W +: FBC_TRIM_W] =
                    feat_r[FBC_LO+n*FBC_TRIM_W +: FBC_TRIM_W]; // [R2]
                dec = fbc_decode(feat_r[FBC_LO+n*FBC_TRIM_W +: FBC_TRIM_W]); // [R3]
                pct_nxt[n*7 +: 7] = dec[6:0];
                bad_nxt[n] = dec[7];
            end
        end
    endgenerate

    // registers of the settings
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bypass_r <= FBC_BIT_RESET;
            trim_r <= '0;
            pct_r <= {FBC_NUM_OUT{FBC_PCT_DEFAULT}};
            bad_r <= '0;
        end else begin
            bypass_r <= bypass_nxt;
            trim_r <= trim_nxt;
            pct_r <= pct_nxt;
            bad_r <= bad_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, each straight from a flip-flop
    assign bypass_short_o = bypass_r;
    assign drive_trim_o = trim_r;
    assign drive_pct_o = pct_r;
    assign drive_code_bad_o = bad_r;
    assign unlocked_o = unlocked_r;
    assign selected_o = select_r;
    assign locked_write_o = locked_r;

endmodule

// file: src/fbc_host.sv
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
// host controller: takes field commands over wishbone, walks the bits
module fbc_host
    import fbc_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // register writes toward the device
    fbc_link_if.host link
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    fbc_hstate_e st_r, st_nxt; // sequencer state
    logic [255:0] shadow_r, shadow_nxt; // copy of the device feature bits
    logic unl_r, unl_nxt; // unlock already sent
    logic [15:0] cmd_r, cmd_nxt; // last accepted command
    logic [1:0] bit_r, bit_nxt; // bit index within the field
    logic err_r, err_nxt; // sticky: wanted zero on a set bit
    logic ign_r, ign_nxt; // sticky: command while busy
    logic [7:0] cnt_r, cnt_nxt; // bits changed
    logic stb_r, stb_nxt; // link strobe
    logic [7:0] reg_r, reg_nxt; // link register number
    logic [7:0] dat_r, dat_nxt; // link data
    logic ack_r, ack_nxt; // wishbone ack
    logic [31:0] rd_r, rd_nxt; // wishbone read data

    logic req; // new wishbone request this cycle
    logic [7:0] cur_addr; // feature bit being worked on
    logic want; // wanted value of that bit

    assign req = wb_cyc_i && wb_stb_i && !ack_r;
    assign cur_addr = cmd_r[FBC_CMD_ADDR_LSB +: 8] + {6'h00, bit_r};
    assign want = cmd_r[FBC_CMD_VAL_LSB + bit_r];

    ////////////////////////////////////////////////////////////////////////////
    // next values: bus slave and bit sequencer
    always_comb begin
        st_nxt = st_r;
        shadow_nxt = shadow_r;
        unl_nxt = unl_r;
        cmd_nxt = cmd_r;
        bit_nxt = bit_r;
        err_nxt = err_r;
        ign_nxt = ign_r;
        cnt_nxt = cnt_r;
        stb_nxt = 1'b0;
        reg_nxt = reg_r;
        dat_nxt = dat_r;
        ack_nxt = req; // answer one cycle after the request
        rd_nxt = 32'h0000_0000;
        // reads; unmapped addresses read zero
        if (req && !wb_we_i) begin
            if (wb_adr_i == FBC_WB_CMD) begin
                rd_nxt = {16'h0000, cmd_r};
            end else if (wb_adr_i == FBC_WB_STATUS) begin
                rd_nxt = {16'h0000, cnt_r, 5'h00, ign_r, err_r, (st_r != FBC_H_IDLE)};
            end
        end
        // sequencer; sticky bits set here win over a clear below
        case (st_r)
            FBC_H_IDLE: begin
                bit_nxt = 2'h0;
            end
            FBC_H_UNLOCK: begin
                stb_nxt = 1'b1;
                reg_nxt = FBC_REG_UNLOCK;
                dat_nxt = FBC_UNLOCK_KEY; // [R4]
                unl_nxt = 1'b1;
                st_nxt = FBC_H_NEXT;
            end
            FBC_H_NEXT: begin
                // skip bits already right; a one cannot be taken back
                if (want == shadow_r[cur_addr]) begin // [R8]
                    st_nxt = FBC_H_SELECT;
                end else if (!want) begin
                    err_nxt = 1'b1;
                    st_nxt = FBC_H_SELECT;
                end else begin
                    stb_nxt = 1'b1;
                    reg_nxt = FBC_REG_SELECT;
                    dat_nxt = cur_addr; // [R5]
                    st_nxt = FBC_H_SET;
                end
                if (st_nxt == FBC_H_SELECT) begin
                    // nothing to write: advance or finish
                    if (bit_r == cmd_r[FBC_CMD_WID_LSB +: 2]) begin
                        st_nxt = FBC_H_IDLE;
                    end else begin
                        bit_nxt = bit_r + 2'h1;
                        st_nxt = FBC_H_NEXT;
                    end
                end
            end
            FBC_H_SET: begin
                stb_nxt = 1'b1;
                reg_nxt = FBC_REG_WRITE;
                dat_nxt = FBC_SET_CMD;
                shadow_nxt[cur_addr] = 1'b1;
                cnt_nxt = cnt_r + 8'h01;
                st_nxt = FBC_H_CLEAR;
            end
            FBC_H_CLEAR: begin
                stb_nxt = 1'b1;
                reg_nxt = FBC_REG_WRITE;
                dat_nxt = FBC_CLEAR_CMD; // [R7]
                st_nxt = FBC_H_SELECT;
            end
            FBC_H_SELECT: begin
                // after the clear, move on to the next bit of the field, or finish after the last one
                if (bit_r == cmd_r[FBC_CMD_WID_LSB +: 2]) begin
                    st_nxt = FBC_H_IDLE;
                end else begin
                    bit_nxt = bit_r + 2'h1;
                    st_nxt = FBC_H_NEXT;
                end
            end
            default: begin
                st_nxt = FBC_H_IDLE;
            end
        endcase
        // writes take effect at the ack edge
        if (req && wb_we_i) begin
            if (wb_adr_i == FBC_WB_CMD && wb_sel_i[1:0] == 2'h3) begin
                if (st_r == FBC_H_IDLE) begin
                    cmd_nxt = wb_dat_i[15:0];
                    bit_nxt = 2'h0;
                    st_nxt = unl_r ? FBC_H_NEXT : FBC_H_UNLOCK;
                end else begin
                    ign_nxt = 1'b1;
                end
            end else if (wb_adr_i == FBC_WB_STATUS && wb_sel_i[0]) begin
                if (wb_dat_i[FBC_ST_CLR_ERR] && st_r != FBC_H_NEXT) err_nxt = 1'b0;
                if (wb_dat_i[FBC_ST_IGNORED] && !(ign_nxt && !ign_r)) ign_nxt = 1'b0;
            end
        end
    end

    // registers
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r <= FBC_H_IDLE;
            shadow_r <= '0;
            unl_r <= 1'b0;
            cmd_r <= 16'h0000;
            bit_r <= 2'h0;
            err_r <= 1'b0;
            ign_r <= 1'b0;
            cnt_r <= 8'h00;
            stb_r <= 1'b0;
            reg_r <= 8'h00;
            dat_r <= 8'h00;
            ack_r <= 1'b0;
            rd_r <= 32'h0000_0000;
        end else begin
            st_r <= st_nxt;
            shadow_r <= shadow_nxt;
            unl_r <= unl_nxt;
            cmd_r <= cmd_nxt;
            bit_r <= bit_nxt;
            err_r <= err_nxt;
            ign_r <= ign_nxt;
            cnt_r <= cnt_nxt;
            stb_r <= stb_nxt;
            reg_r <= reg_nxt;
            dat_r <= dat_nxt;
            ack_r <= ack_nxt;
            rd_r <= rd_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs from flip-flops
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rd_r;
    assign link.wr_stb = stb_r;
    assign link.wr_reg = reg_r;
    assign link.wr_data = dat_r;

endmodule

// file: verification/fbc_assertions.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// link and settings checks beside the host-device pair
module fbc_assertions
    import fbc_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // link signals
    input wire logic wr_stb,
    input wire logic [7:0] wr_reg,
    input wire logic [7:0] wr_data,
    // device settings and state
    input wire logic bypass_short_o,
    input wire logic [FBC_NUM_OUT*FBC_TRIM_W-1:0] drive_trim_o,
    input wire logic unlocked_o,
    input wire logic [7:0] selected_o
);
    logic set_cmd; // set command on the link
    logic sel_stb; // select write on the link
    logic clr_stb; // clear command on the link
    logic [7:0] sel_r; // select one edge back
    logic pend_r; // a set still waits for its clear
    logic pend_nxt;
    assign set_cmd = wr_stb && wr_reg == FBC_REG_WRITE && wr_data == FBC_SET_CMD;
    assign sel_stb = wr_stb && wr_reg == FBC_REG_SELECT;
    assign clr_stb = wr_stb && wr_reg == FBC_REG_WRITE && wr_data == FBC_CLEAR_CMD;
    // pending: set raises, clear drops
    always_comb begin
        pend_nxt = pend_r;
        if (set_cmd) begin
            pend_nxt = 1'b1;
        end else if (clr_stb) begin
            pend_nxt = 1'b0;
        end
    end
    // helper flops
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pend_r <= 1'b0;
            sel_r <= 8'h00;
        end else begin
            pend_r <= pend_nxt;
            sel_r <= selected_o;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    chk_key_first: assert property (wr_stb && !unlocked_o |-> wr_reg == FBC_REG_UNLOCK)
        else $error("link write before the unlock key");
    chk_unlock_open: assert property (wr_stb && wr_reg == FBC_REG_UNLOCK
        && wr_data == FBC_UNLOCK_KEY |=> unlocked_o)
        else $error("unlock key did not open the registers");
    chk_select_take: assert property (sel_stb && unlocked_o |=> selected_o == $past(wr_data))
        else $error("select byte not taken");
    chk_bypass_set: assert property (unlocked_o && set_cmd && selected_o == FBC_BYPASS_BIT
        |=> ##1 bypass_short_o)
        else $error("bypass bit not set");
    chk_trim_set: assert property (unlocked_o && set_cmd && selected_o >= FBC_TRIM_BASE
        && selected_o <= FBC_TRIM_LAST |=> ##1 drive_trim_o[sel_r - FBC_TRIM_BASE])
        else $error("selected trim bit not set");
    chk_set_cause: assert property ($changed(drive_trim_o) || $rose(bypass_short_o)
        |-> $past(set_cmd, 2))
        else $error("setting changed without a set command");
    chk_only_rise: assert property (!$fell(bypass_short_o)
        && ($past(drive_trim_o) & ~drive_trim_o) == '0)
        else $error("feature bit dropped without reset");
    chk_clear_first: assert property (sel_stb |-> !pend_r)
        else $error("select before the clear command");
    chk_clear_soon: assert property (set_cmd |=> ##[0:15] clr_stb)
        else $error("clear command missing after set");
    cov_unlock: cover property (wr_stb && wr_reg == FBC_REG_UNLOCK);
    cov_bypass: cover property ($rose(bypass_short_o));
    cov_set_clear: cover property (set_cmd ##[1:8] clr_stb);
endmodule

// file: verification/feature_bit_config_access_tb.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// host and device back to back, plus a second device poked by hand
module feature_bit_config_access_tb
    import fbc_pkg::*;
;
    localparam int NT = FBC_NUM_OUT * FBC_TRIM_W; // trim vector width
    typedef struct packed {
        logic [4:0] out; // output number
        logic [3:0] code; // trim code asked for
        logic [6:0] pct; // drive level expected
    } fbc_row_s;
    fbc_row_s rows [11] = '{
        '{5'h00, 4'h0, 7'h64}, '{5'h01, 4'h1, 7'h5a}, '{5'h02, 4'h3, 7'h50},
        '{5'h03, 4'h4, 7'h46}, '{5'h04, 4'h6, 7'h3c}, '{5'h05, 4'h7, 7'h32},
        '{5'h06, 4'ha, 7'h28}, '{5'h07, 4'hb, 7'h1e}, '{5'h08, 4'hc, 7'h14},
        '{5'h09, 4'he, 7'h0a}, '{5'h12, 4'hf, 7'h00}};
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat_w = 32'h0;
    logic [31:0] wb_dat_r, rd;
    logic wb_ack, bypass_a, unl_a, bypass_b, unl_b, lw_b, lw_seen;
    logic [7:0] sel_a, sel_b;
    logic [NT-1:0] trim_a, trim_b, exp_trim;
    logic [FBC_NUM_OUT*7-1:0] pct_a;
    logic [FBC_NUM_OUT-1:0] bad_a;
    int mismatches = 0;
    int n_compared = 0;
    int n_sets = 0; // set commands seen on the first link
    int base;
    fbc_link_if lk_a();
    fbc_link_if lk_b();
    fbc_host u_fbc_host (.clock_i(clock_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf),
        .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .link(lk_a));
    fbc_device u_fbc_device (.clock_i(clock_i), .reset_n_i(reset_n_i), .link(lk_a),
        .bypass_short_o(bypass_a), .drive_trim_o(trim_a), .drive_pct_o(pct_a),
        .drive_code_bad_o(bad_a), .unlocked_o(unl_a), .selected_o(sel_a), .locked_write_o());
    // second device, driven by the bench
    fbc_device u_fbc_device_b (.clock_i(clock_i), .reset_n_i(reset_n_i), .link(lk_b),
        .bypass_short_o(bypass_b), .drive_trim_o(trim_b), .drive_pct_o(),
        .drive_code_bad_o(), .unlocked_o(unl_b), .selected_o(sel_b), .locked_write_o(lw_b));
    fbc_assertions u_fbc_assertions (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .wr_stb(lk_a.wr_stb), .wr_reg(lk_a.wr_reg), .wr_data(lk_a.wr_data),
        .bypass_short_o(bypass_a), .drive_trim_o(trim_a), .unlocked_o(unl_a), .selected_o(sel_a));
    always #2.5 clock_i = ~clock_i;
    // count sets mid-cycle
    always @(negedge clock_i) begin
        if (lk_a.wr_stb === 1'b1 && lk_a.wr_reg === FBC_REG_WRITE
            && lk_a.wr_data === FBC_SET_CMD) begin
            n_sets++;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [NT-1:0] seen, input logic [NT-1:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task timed_out;
        mismatches++;
        $display("Error at %0t: wait ran out", $time);
        stop_test();
    endtask
    // one classic cycle; the slave's latency is not assumed
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                            output logic [31:0] data);
        int k;
        k = 0;
        @(posedge clock_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat_w <= dat;
        do begin
            @(posedge clock_i);
            k++;
        end while (wb_ack !== 1'b1 && k < 50);
        data = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        if (k >= 50) begin
            timed_out();
        end
    endtask
    // field command, then poll busy
    task automatic field(input logic [7:0] start, input logic [1:0] wid, input logic [3:0] val);
        int n;
        n = 0;
        wb_cycle(1'b1, FBC_WB_CMD, {16'h0, val, 2'b00, wid, start}, rd);
        do begin
            wb_cycle(1'b0, FBC_WB_STATUS, 32'h0, rd);
            n++;
        end while (rd[FBC_ST_BUSY] !== 1'b0 && n < 200);
        if (n >= 200) begin
            timed_out();
        end
        @(negedge clock_i);
    endtask
    // one strobe on the second link
    task automatic poke_b(input logic [7:0] r, input logic [7:0] d);
        @(posedge clock_i);
        lk_b.wr_stb <= 1'b1;
        lk_b.wr_reg <= r;
        lk_b.wr_data <= d;
        @(posedge clock_i);
        lk_b.wr_stb <= 1'b0;
        @(negedge clock_i);
        lw_seen = lw_b;
        @(posedge clock_i);
        @(negedge clock_i);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        lk_b.wr_stb = 1'b0;
        lk_b.wr_reg = 8'h00;
        lk_b.wr_data = 8'h00;
        exp_trim = '0;
        repeat (12) @(posedge clock_i);
        reset_n_i <= 1'b1;
        @(negedge clock_i);
        check(bypass_a, 1'b0);
        check(pct_a[6:0], 7'h64);
        check(unl_a, 1'b0);
        $display("test reset done");
        // each row sets one output code
        foreach (rows[i]) begin
            base = 4 * rows[i].out;
            field(FBC_TRIM_BASE + 8'(base), 2'h3, rows[i].code);
            exp_trim[base +: 4] = rows[i].code;
            check(trim_a, exp_trim);
            check(pct_a[7 * rows[i].out +: 7], rows[i].pct);
            check(bad_a[rows[i].out], 1'b0);
        end
        $display("test rows done");
        field(FBC_BYPASS_BIT, 2'h0, 4'h1);
        check(bypass_a, 1'b1);
        base = n_sets;
        field(8'h90, 2'h3, 4'h7); // output 1 from 0001 to 0111
        exp_trim[7:4] = 4'h7;
        check(n_sets - base, 2);
        check(trim_a, exp_trim);
        field(8'h94, 2'h3, 4'h0); // output 2 asks for bits to drop
        check(rd[FBC_ST_CLR_ERR], 1'b1);
        check(trim_a, exp_trim);
        wb_cycle(1'b1, FBC_WB_CMD, 32'hf3b8, rd); // output 11 to 1111
        field(8'hbc, 2'h3, 4'hf); // output 12, sent while busy
        exp_trim[47:44] = 4'hf;
        check(trim_a, exp_trim);
        check(rd[FBC_ST_IGNORED], 1'b1);
        wb_cycle(1'b1, FBC_WB_STATUS, 32'h6, rd); // ones clear the sticky bits
        wb_cycle(1'b0, FBC_WB_STATUS, 32'h0, rd);
        check(rd[2:1], 2'b00);
        wb_cycle(1'b0, 8'h40, 32'h0, rd); // unmapped place reads zero
        check(rd, 32'h0);
        $display("test host sequences done");
        // second device: locked writes, missing clears, out-of-range bits
        poke_b(FBC_REG_SELECT, 8'h91);
        check({lw_seen, sel_b}, 9'h100);
        poke_b(FBC_REG_WRITE, FBC_SET_CMD);
        check({lw_seen, trim_b}, {1'b1, NT'(0)});
        poke_b(FBC_REG_UNLOCK, FBC_UNLOCK_KEY);
        check(unl_b, 1'b1);
        poke_b(FBC_REG_SELECT, 8'h91);
        check({lw_seen, sel_b}, 9'h091);
        poke_b(FBC_REG_WRITE, FBC_SET_CMD);
        poke_b(FBC_REG_SELECT, 8'h92);
        poke_b(FBC_REG_WRITE, FBC_SET_CMD);
        check(trim_b, NT'(8'h60));
        poke_b(FBC_REG_SELECT, 8'hd8);
        poke_b(FBC_REG_WRITE, FBC_SET_CMD);
        check({bypass_b, trim_b}, {1'b0, NT'(8'h60)});
        poke_b(FBC_REG_UNLOCK, 8'h00);
        check(unl_b, 1'b0);
        $display("test second device done");
        // mid-run reset clears all and relocks
        @(posedge clock_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        reset_n_i <= 1'b1;
        @(negedge clock_i);
        check({unl_a, bypass_a, trim_a}, '0);
        field(FBC_BYPASS_BIT, 2'h0, 4'h1);
        check(bypass_a, 1'b1);
        $display("test second reset done");
        stop_test();
    end
endmodule
